/* design/tsl_top.sv */
// speed limit selection, analog scaling, offset capture and edit lock
// Overview of operation
// [R1] entry 0 analog: speed from internal knob
// [R2] entry 1 analog: speed from external voltage
// [R3] voltage scaled by gain r/min per volt
// [R4] offset voltage subtracted before gain
// [R5] auto offset captures input on apply
// [R6] manual offset uses offset parameter
// [R7] analog mode: entries 2-7 stored digital
// [R8] digital mode: all entries stored digital
// [R9] analog enable latched only at power-up
// [R10] 5 s key hold toggles edit lock
// [R11] locked: data and parameter writes rejected
// [R12] entry number is binary of selects
// [R13] limit active when speed reaches limit
// [R14] analog limit clamped 0 to 5500
module tsl_top
   import tsl_pkg::*;
#(
   parameter longint HOLD_CYC = LOCK_HOLD_CYC
)
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [ADDR_W-1:0]        addr,
   input  wire logic [DATA_W-1:0]        wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [DATA_W-1:0]        rdata,
   input  wire logic                     data_select_bit0,
   input  wire logic                     data_select_bit1,
   input  wire logic                     data_select_bit2,
   input  wire logic                     analog_enable_cfg,
   input  wire logic [RPM_W-1:0]         internal_speed_knob,
   input  wire logic signed [MV_W-1:0]   analog_speed_mv,
   input  wire logic [RPM_W-1:0]         detected_rpm,
   input  wire logic                     mode_key,
   input  wire logic                     top_screen,
   output logic      [RPM_W-1:0]         speed_limit_rpm,
   output logic                          speed_limit_active,
   output logic                          lock_led,
   output tsl_msg_t                      lock_msg
);

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;

   // pins from the controller and the key pass two flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {top_screen, mode_key, data_select_bit2,
                     data_select_bit1, data_select_bit0};
         sync2_q <= sync1_q;
      end
   end

   logic [2:0] entry;
   logic       key_s;
   logic       top_s;
   assign entry = sync2_q[2:0];   // R12
   assign key_s = sync2_q[3];
   assign top_s = sync2_q[4];

   // ------------------------------------------------------------------
   // power-up latch of the analog enable setting
   // ------------------------------------------------------------------
   logic init_done_q;
   logic an_en_q;

   // sampled once after reset release; later changes wait for power cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         init_done_q <= 1'b0;
         an_en_q     <= 1'b0;
      end
      else if (!init_done_q)
      begin
         init_done_q <= 1'b1;
         an_en_q     <= analog_enable_cfg;   // R9
      end
   end

   // ------------------------------------------------------------------
   // edit lock key timer
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {TSL_IDLE, TSL_HOLD, TSL_WAIT_REL} tsl_lock_st_t;
   tsl_lock_st_t state_q;
   logic [31:0]  hold_cnt_q;
   logic         lock_q;
   tsl_msg_t     msg_q;
   logic         hold_done;

   assign hold_done = (hold_cnt_q == 32'(HOLD_CYC - 1));

   // one toggle per press; key must be released before the next
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q    <= TSL_IDLE;
         hold_cnt_q <= '0;
         lock_q     <= 1'b0;
         msg_q      <= TSL_MSG_NONE;
      end
      else
      begin
         unique case (state_q)
            TSL_IDLE:
            begin
               hold_cnt_q <= '0;
               if (key_s && top_s)
                  state_q <= TSL_HOLD;
            end
            TSL_HOLD:
            begin
               if (!key_s || !top_s)
                  state_q <= TSL_IDLE;
               else if (hold_done)
               begin
                  lock_q  <= !lock_q;                                   // R10
                  msg_q   <= lock_q ? TSL_MSG_UNLOCK : TSL_MSG_LOCK;    // R10
                  state_q <= TSL_WAIT_REL;
               end
               else
                  hold_cnt_q <= hold_cnt_q + 32'd1;
            end
            TSL_WAIT_REL:
            begin
               if (!key_s)
                  state_q <= TSL_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   logic                     auto_off_q;
   logic [RPM_W-1:0]         gain_q;
   logic signed [MV_W-1:0]   offset_q;
   logic signed [MV_W-1:0]   captured_q;
   logic [RPM_W-1:0]         data_q [8];
   logic                     wr_ok;
   logic                     apply;

   // every parameter change is refused while locked
   assign wr_ok = wr && !lock_q;                                        // R11
   assign apply = wr_ok && (addr == OFF_CMD) && wdata[CMD_APPLY_BIT];

   // analog parameters and offset capture
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         auto_off_q <= 1'b0;
         gain_q     <= RST_GAIN;
         offset_q   <= RST_OFFSET;
         captured_q <= '0;
      end
      else
      begin
         if (wr_ok && addr == OFF_CTRL)
            auto_off_q <= wdata[CTRL_AUTO_BIT];
         if (wr_ok && addr == OFF_GAIN)
            gain_q <= (wdata[RPM_W-1:0] > MAX_RPM) ? MAX_RPM : wdata[RPM_W-1:0];
         if (wr_ok && addr == OFF_OFFSET)
            offset_q <= wdata[MV_W-1:0];
         if (apply && auto_off_q)
            captured_q <= analog_speed_mv;   // R5
      end
   end

   // eight stored digital limits
   for (genvar i = 0; i < 8; i++)
   begin : g_data
      always_ff @(posedge clk)
      begin
         if (rst)
            data_q[i] <= RST_DATA;
         else if (wr_ok && addr == OFF_DATA0 + 8'(4 * i))
            data_q[i] <= (wdata[RPM_W-1:0] > MAX_RPM) ? MAX_RPM : wdata[RPM_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // analog scaling and selection
   // ------------------------------------------------------------------
   logic signed [MV_W-1:0] off_use;
   logic [RPM_W-1:0]       scaled;
   logic [RPM_W-1:0]       knob_lim;
   logic [RPM_W-1:0]       data_sel;
   logic [RPM_W-1:0]       limit_d;

   assign off_use  = auto_off_q ? captured_q : offset_q;                // R5 R6
   assign knob_lim = (internal_speed_knob > MAX_RPM) ? MAX_RPM : internal_speed_knob;
   assign data_sel = data_q[entry];

   tsl_scale u_scale (
      .clk       (clk),
      .rst       (rst),
      .volt_mv   (analog_speed_mv),
      .offset_mv (off_use),
      .gain_rpm  (gain_q),
      .limit_q   (scaled)
   );

   // entries 0 and 1 are analog only when enabled at power-up
   always_comb
   begin
      if (an_en_q && entry == 3'd0)
         limit_d = knob_lim;                 // R1
      else if (an_en_q && entry == 3'd1)
         limit_d = scaled;                   // R2
      else
         limit_d = data_sel;                 // R7 R8
   end

   // selected limit and limit-active flag
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         speed_limit_rpm    <= '0;
         speed_limit_active <= 1'b0;
      end
      else
      begin
         speed_limit_rpm    <= limit_d;
         speed_limit_active <= (detected_rpm >= speed_limit_rpm);   // R13
      end
   end

   // indicator outputs mirror the lock state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lock_led <= 1'b0;
         lock_msg <= TSL_MSG_NONE;
      end
      else
      begin
         lock_led <= lock_q;   // R10
         lock_msg <= msg_q;
      end
   end

   // ------------------------------------------------------------------
   // read path, one cycle after the strobe
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] rd_d;

   always_comb
   begin
      rd_d = '0;
      unique case (addr)
         OFF_CTRL:     rd_d[CTRL_AUTO_BIT] = auto_off_q;
         OFF_GAIN:     rd_d[RPM_W-1:0] = gain_q;
         OFF_OFFSET:   rd_d[MV_W-1:0] = offset_q;
         OFF_STATUS:
         begin
            rd_d[ST_ANEN_BIT] = an_en_q;
            rd_d[ST_LOCK_BIT] = lock_q;
            rd_d[ST_ACT_BIT]  = speed_limit_active;
            rd_d[ST_ENTRY_LSB +: 3] = entry;
         end
         OFF_CAPTURED: rd_d[MV_W-1:0] = captured_q;
         OFF_LIMIT:    rd_d[RPM_W-1:0] = speed_limit_rpm;
         default:
         begin
            if (addr >= OFF_DATA0 && addr < OFF_DATA0 + 8'h20 && addr[1:0] == 2'b00)
               rd_d[RPM_W-1:0] = data_q[3'(addr[4:2])];
         end
      endcase
   end

   // data held only in the cycle after a read strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata <= '0;
      else
         rdata <= rd ? rd_d : '0;
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence key_held_s;
      state_q == TSL_HOLD && key_s && top_s && hold_done;
   endsequence

   sequence lock_shown_s;
      lock_q != $past(lock_q) ##1 lock_led == lock_q;
   endsequence

   knob_select_a: assert property (@(posedge clk) disable iff (rst) // R1
      (an_en_q && entry == 3'd0) |=> speed_limit_rpm == $past(knob_lim))
      else $error("knob not selected for entry 0");

   ext_select_a: assert property (@(posedge clk) disable iff (rst) // R2
      (an_en_q && entry == 3'd1) |=> speed_limit_rpm == $past(scaled))
      else $error("scaled voltage not selected for entry 1");

   digital_select_a: assert property (@(posedge clk) disable iff (rst) // R8
      (!an_en_q || entry > 3'd1) |=> speed_limit_rpm == $past(data_sel))
      else $error("stored limit not selected");

   limit_active_a: assert property (@(posedge clk) disable iff (rst) // R13
      (detected_rpm >= speed_limit_rpm) |=> speed_limit_active)
      else $error("limit active flag missing");

   power_latch_a: assert property (@(posedge clk) disable iff (rst) // R9
      init_done_q |=> $stable(an_en_q))
      else $error("analog enable changed while running");

   lock_toggle_a: assert property (@(posedge clk) disable iff (rst) // R10
      key_held_s |=> lock_shown_s)
      else $error("lock did not toggle after hold");

   lock_reject_a: assert property (@(posedge clk) disable iff (rst) // R11
      (lock_q && wr) |=> $stable(gain_q) && $stable(offset_q) && $stable(data_q[0]))
      else $error("write accepted while locked");

   offset_capture_a: assert property (@(posedge clk) disable iff (rst) // R5
      (apply && auto_off_q) |=> captured_q == $past(analog_speed_mv))
      else $error("offset not captured on apply");

   manual_offset_a: assert property (@(posedge clk) disable iff (rst) // R6
      !auto_off_q |-> off_use == offset_q)
      else $error("manual offset not used");

endmodule

/* design/tsl_pkg.sv */
// shared constants for the tension speed limit selector
package tsl_pkg;

   // ------------------------------------------------------------------
   // bus geometry and register byte offsets
   // ------------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          RPM_W         = 13;
   localparam int          MV_W          = 16;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_GAIN      = 8'h04;
   localparam logic [7:0]  OFF_OFFSET    = 8'h08;
   localparam logic [7:0]  OFF_CMD       = 8'h0C;
   localparam logic [7:0]  OFF_STATUS    = 8'h10;
   localparam logic [7:0]  OFF_CAPTURED  = 8'h14;
   localparam logic [7:0]  OFF_LIMIT     = 8'h18;
   localparam logic [7:0]  OFF_DATA0     = 8'h20;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int          CTRL_AUTO_BIT = 0;
   localparam int          CMD_APPLY_BIT = 0;
   localparam int          ST_ANEN_BIT   = 0;
   localparam int          ST_LOCK_BIT   = 1;
   localparam int          ST_ACT_BIT    = 2;
   localparam int          ST_ENTRY_LSB  = 4;

   // ------------------------------------------------------------------
   // reset values and limits
   // ------------------------------------------------------------------
   localparam logic [12:0] RST_GAIN      = 13'h0226;   // 550 r/min per volt
   localparam logic [15:0] RST_OFFSET    = 16'h0000;   // 0 mV
   localparam logic [12:0] RST_DATA      = 13'h0000;   // 0 r/min
   localparam logic [12:0] MAX_RPM       = 13'h157C;   // 5500 r/min
   localparam int          MV_PER_V      = 1000;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam longint      CLK_PERIOD_PS = 5000;
   localparam longint      LOCK_HOLD_MS  = 5000;
   localparam longint      LOCK_HOLD_CYC = (LOCK_HOLD_MS * 64'd1_000_000_000
                                            + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // display message codes
   typedef enum logic [1:0] {TSL_MSG_NONE, TSL_MSG_LOCK, TSL_MSG_UNLOCK} tsl_msg_t;

endpackage

/* design/tsl_scale.sv */
// analog voltage to speed limit scaler with offset and clamp
module tsl_scale
   import tsl_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic signed [MV_W-1:0]  volt_mv,
   input  wire logic signed [MV_W-1:0]  offset_mv,
   input  wire logic        [RPM_W-1:0] gain_rpm,
   output logic             [RPM_W-1:0] limit_q
);

   // ------------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------------
   logic signed [MV_W:0]   diff;
   logic        [31:0]     prod;
   logic        [31:0]     quot;
   logic        [RPM_W-1:0] limit_d;

   // offset is the zero point, subtracted before the gain
   assign diff = (MV_W+1)'(volt_mv) - (MV_W+1)'(offset_mv);   // R4

   // negative or zero gives no speed; clamp above full range
   always_comb
   begin
      prod    = '0;
      quot    = '0;
      limit_d = '0;
      if (diff > 0)                                       // R14
      begin
         prod = 32'(unsigned'(diff)) * 32'(gain_rpm);     // R3
         quot = prod / 32'(MV_PER_V);
         limit_d = (quot > 32'(MAX_RPM)) ? MAX_RPM : quot[RPM_W-1:0];  // R14
      end
   end

   // one register stage keeps the divider off the select path
   always_ff @(posedge clk)
   begin
      if (rst)
         limit_q <= '0;
      else
         limit_q <= limit_d;
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   clamp_range_a: assert property (@(posedge clk) disable iff (rst) // R14
      limit_q <= MAX_RPM)
      else $error("scaled limit above full range");

   zero_point_a: assert property (@(posedge clk) disable iff (rst) // R4
      (volt_mv <= offset_mv) |=> limit_q == '0)
      else $error("voltage at or under offset not zero");

endmodule

/* verification/tsl_ctrl_model.sv */
// controller model that drives the three entry select pins
module tsl_ctrl_model
(
   input  wire logic       clk,
   input  wire logic [2:0] entry_req,
   output logic            data_select_bit0,
   output logic            data_select_bit1,
   output logic            data_select_bit2
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------
   // pin drive
   // ------------------------------------------------
   // pins move only just after an edge; the block syncs them anyway
   always @(posedge clk)
   begin
      {data_select_bit2, data_select_bit1, data_select_bit0} <= entry_req;
   end
endmodule

/* verification/tb_tsl_top.sv */
// self-checking bench for the tension speed limit selector
module tb_tsl_top
   import tsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   localparam int          HOLD = 16;
   logic                   clk, rst, wr, rd, an_en, key, top;
   logic                   s0, s1, s2, act, led;
   logic [ADDR_W-1:0]      addr;
   logic [DATA_W-1:0]      wdata, rdata, rv;
   logic [2:0]             sel;
   logic [RPM_W-1:0]       knob, det, lim;
   logic signed [MV_W-1:0] mv;
   tsl_msg_t               msg;
   int                     n_mismatch, compares, i;

   // rows: select, knob, voltage in mV, expected limit
   typedef struct {logic [2:0] s; logic [12:0] k; logic [15:0] v; logic [12:0] e;} tsl_row_t;
   tsl_row_t rows [9] = '{
      '{3'h0, 13'h04D2, 16'h07D0, 13'h04D2},
      '{3'h0, 13'h1770, 16'h0000, 13'h157C},
      '{3'h1, 13'h0010, 16'h07D0, 13'h044C},
      '{3'h2, 13'h0010, 16'h07D0, 13'h0102},
      '{3'h3, 13'h0010, 16'h07D0, 13'h0103},
      '{3'h4, 13'h0010, 16'h07D0, 13'h0104},
      '{3'h5, 13'h0010, 16'h07D0, 13'h0105},
      '{3'h6, 13'h0010, 16'h07D0, 13'h0106},
      '{3'h7, 13'h0010, 16'h07D0, 13'h0107}};

   // ------------------------------------------------
   // clock, partner, design
   // ------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   tsl_ctrl_model ctrl (.clk(clk), .entry_req(sel), .data_select_bit0(s0),
                        .data_select_bit1(s1), .data_select_bit2(s2));

   tsl_top #(.HOLD_CYC(HOLD)) dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .data_select_bit0(s0), .data_select_bit1(s1),
      .data_select_bit2(s2), .analog_enable_cfg(an_en), .internal_speed_knob(knob),
      .analog_speed_mv(mv), .detected_rpm(det), .mode_key(key), .top_screen(top),
      .speed_limit_rpm(lim), .speed_limit_active(act), .lock_led(led), .lock_msg(msg));

   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_out(input string nm, input logic [12:0] e, input logic [12:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // covers sync, scaler and output register with margin
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic press(input int n);
      @(posedge clk);
      key <= 1'b1;
      repeat (n) @(posedge clk);
      key <= 1'b0;
      settle();
   endtask

   // analog enable held steady across the first edge after release
   task automatic do_reset(input logic cfg);
      @(posedge clk);
      rst <= 1'b1;
      an_en <= cfg;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      #100us;
      n_mismatch++;
      wrap_up();
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      // reset high from time zero so no edge sees an unreset design
      {rst, wr, rd, key, top, an_en} = 6'h20;
      {addr, wdata, sel, knob, mv, det} = '0;
      do_reset(1'b1);
      rd_reg(OFF_GAIN, rv);     chk_reg("gain", 32'h0000_0226, rv);
      rd_reg(OFF_OFFSET, rv);   chk_reg("offset", 32'h0000_0000, rv);
      rd_reg(8'h3C, rv);        chk_reg("data7", 32'h0000_0000, rv);
      rd_reg(OFF_CMD, rv);      chk_reg("cmd", 32'h0000_0000, rv);
      rd_reg(8'hFC, rv);        chk_reg("unmapped", 32'h0000_0000, rv);
      rd_reg(OFF_STATUS, rv);   chk_reg("an_en", 32'h0000_0001, rv & 32'h1);
      for (i = 0; i < 8; i++)
         wr_reg(OFF_DATA0 + 8'(4 * i), 32'h0000_0100 + i);
      foreach (rows[r])
      begin
         sel <= rows[r].s;
         knob <= rows[r].k;
         mv <= rows[r].v;
         settle();
         chk_out("row limit", rows[r].e, lim);
      end
      // gain, negative result and overflow clamp on entry 1
      sel <= 3'h1;
      wr_reg(OFF_GAIN, 32'h0000_000A);
      settle();                 chk_out("gain 10", 13'h0014, lim);
      mv <= 16'hFE0C;
      settle();                 chk_out("negative", 13'h0000, lim);
      wr_reg(OFF_GAIN, 32'h0000_157C);
      mv <= 16'h0BB8;
      settle();                 chk_out("overflow", 13'h157C, lim);
      // manual offset of one volt
      wr_reg(OFF_GAIN, 32'h0000_0226);
      wr_reg(OFF_OFFSET, 32'h0000_03E8);
      mv <= 16'h03E8;
      settle();                 chk_out("at offset", 13'h0000, lim);
      mv <= 16'h0BB8;
      settle();                 chk_out("above off", 13'h044C, lim);
      // auto offset: capture differs from the stored offset on purpose
      wr_reg(OFF_CTRL, 32'h0000_0001);
      mv <= 16'h012C;
      settle();
      wr_reg(OFF_CMD, 32'h0000_0001);
      rd_reg(OFF_CAPTURED, rv); chk_reg("captured", 32'h0000_012C, rv);
      mv <= 16'h08FC;
      settle();                 chk_out("auto off", 13'h044C, lim);
      // limit active exactly at the limit
      sel <= 3'h2;
      det <= 13'h0101;
      settle();                 chk_out("below", 13'h0000, 13'(act));
      det <= 13'h0102;
      settle();                 chk_out("reached", 13'h0001, 13'(act));
      // edit lock: short press, lock, refused writes, off-screen, unlock
      top <= 1'b1;
      press(8);                 chk_out("short", 13'h0000, 13'(led));
      press(HOLD + 10);         chk_out("lock led", 13'h0001, 13'(led));
      chk_out("lock msg", 13'(TSL_MSG_LOCK), 13'(msg));
      // status: analog on, locked, limit active, entry 2
      rd_reg(OFF_STATUS, rv);   chk_reg("status", 32'h0000_0027, rv);
      rd_reg(OFF_LIMIT, rv);    chk_reg("limit reg", 32'h0000_0102, rv);
      wr_reg(OFF_DATA0 + 8'h08, 32'h0000_0999);
      wr_reg(OFF_GAIN, 32'h0000_0005);
      rd_reg(OFF_DATA0 + 8'h08, rv); chk_reg("lock data", 32'h0000_0102, rv);
      rd_reg(OFF_GAIN, rv);     chk_reg("lock gain", 32'h0000_0226, rv);
      top <= 1'b0;
      press(HOLD + 10);         chk_out("off screen", 13'h0001, 13'(led));
      top <= 1'b1;
      press(HOLD + 10);         chk_out("unlock led", 13'h0000, 13'(led));
      chk_out("unlock msg", 13'(TSL_MSG_UNLOCK), 13'(msg));
      wr_reg(OFF_DATA0 + 8'h08, 32'h0000_0200);
      rd_reg(OFF_DATA0 + 8'h08, rv); chk_reg("free data", 32'h0000_0200, rv);
      // analog enable ignored while running, taken at the next reset
      an_en <= 1'b0;
      knob <= 13'h0300;
      sel <= 3'h0;
      settle();
      rd_reg(OFF_STATUS, rv);   chk_reg("an_en run", 32'h0000_0001, rv & 32'h1);
      chk_out("still knob", 13'h0300, lim);
      do_reset(1'b0);
      rd_reg(OFF_STATUS, rv);   chk_reg("an_en new", 32'h0000_0000, rv & 32'h1);
      for (i = 0; i < 8; i++)
      begin
         wr_reg(OFF_DATA0 + 8'(4 * i), 32'h0000_0400 + i);
         sel <= 3'(i);
         settle();
         chk_out("digital", 13'h0400 + 13'(i), lim);
      end
      wrap_up();
   end
endmodule
